// ===== rtl/sars_seq.v
`timescale 1ns/1ns
`include "sars_map.vh"

module sars_fifo #(
	parameter W  = 8,
	parameter D  = 32,
	parameter AW = 5
) (
	input  wire          clk,
	input  wire          reset,
	input  wire          in_valid,
	output wire          in_ready,
	input  wire [W-1:0]  in_data,
	output wire          out_valid,
	input  wire          out_ready,
	output wire [W-1:0]  out_data
);
	reg [W-1:0]  mem [0:D-1];
	reg [AW-1:0] wptr;
	reg [AW-1:0] rptr;
	reg [AW:0]   count;
	wire         push;
	wire         pop;

	assign in_ready  = (count != D[AW:0]);
	assign out_valid = (count != {(AW+1){1'b0}});
	assign out_data  = mem[rptr];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	always @(posedge clk) begin
		if (push) begin
			mem[wptr] <= in_data;
		end
	end

	always @(posedge clk) begin
		if (reset) begin
			wptr  <= {AW{1'b0}};
			rptr  <= {AW{1'b0}};
			count <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wptr <= (wptr == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wptr + 1'b1;
			end
			if (pop) begin
				rptr <= (rptr == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rptr + 1'b1;
			end
			if (push & ~pop) begin
				count <= count + 1'b1;
			end else if (pop & ~push) begin
				count <= count - 1'b1;
			end
		end
	end
endmodule // sars_fifo

module sars_seq #(
	parameter AW         = 10,
	parameter FIFO_DEPTH = 32,
	parameter FIFO_AW    = 5,
	parameter CONV_LIMIT = `SARS_CONV_MAX_CYC
) (
	input  wire          clk,
	input  wire          reset,
	input  wire          select_n_pin,
	input  wire          shift_clk_pin,
	input  wire [AW-1:0] ain,
	input  wire [AW-1:0] ref_hi,
	input  wire [AW-1:0] ref_lo,
	output reg           sdo,
	output reg           sdo_oe,
	output reg           conv_busy
);
	reg [2:0]    sel_sync;
	reg [2:0]    sclk_sync;
	reg          sel_lvl;
	reg          sclk_lvl;
	reg [7:0]    osc_div;
	reg          osc;
	reg [1:0]    state;
	reg [1:0]    q_rise;
	reg          q_fall;
	reg [3:0]    edge_cnt;
	reg [7:0]    shreg;
	reg [7:0]    last_res;
	reg [AW-1:0] held;
	reg [5:0]    tick;
	reg [7:0]    sar;
	reg [7:0]    mask;
	reg          done;
	reg [15:0]   guard;
	wire         next_sel;
	wire         next_sclk;
	wire         sel_fall;
	wire         sclk_fall;
	wire         osc_edge;
	wire         osc_rise;
	wire         osc_fall;
	wire         qualified;
	wire         load;
	wire         start;
	wire         push_ready;
	wire         pop_valid;
	wire [7:0]   pop_data;
	wire [7:0]   trial;

	// a level moves only once the second and third stages agree
	function stable;
		input s2;
		input s3;
		input lvl;
		begin
			stable = (s2 == s3) ? s2 : lvl;
		end
	endfunction

	function [AW+7:0] thr;
		input [7:0]    t;
		input [AW-1:0] lo;
		input [AW-1:0] hi;
		reg   [AW+7:0] prod;
		begin
			prod = {8'h00, hi - lo} * {{AW{1'b0}}, t};
			thr  = {8'h00, lo} + (prod >> 8);
		end
	endfunction

	assign next_sel  = stable(sel_sync[1], sel_sync[2], sel_lvl);
	assign next_sclk = stable(sclk_sync[1], sclk_sync[2], sclk_lvl);
	assign sel_fall  = sel_lvl & ~next_sel;
	assign sclk_fall = sclk_lvl & ~next_sclk;

	// free-running oscillator, never gated by the host clock
	assign osc_edge = (osc_div == `SARS_OSC_HALF - 1);
	assign osc_rise = osc_edge & ~osc;
	assign osc_fall = osc_edge & osc;

	// noise filter on select: wait out internal clock edges
	assign qualified = (q_rise == `SARS_QUAL_RISES) & q_fall;
	assign load      = (state == `SARS_ST_QUAL) & qualified;
	assign start     = (state == `SARS_ST_SHIFT) & sclk_fall
	                 & (edge_cnt == `SARS_FRAME_EDGES - 1);
	assign trial     = sar | mask;

	always @(posedge clk) begin
		if (reset) begin
			sel_sync  <= 3'h7;
			sclk_sync <= 3'h0;
			sel_lvl   <= 1'b1;
			sclk_lvl  <= 1'b0;
			osc_div   <= 8'h00;
			osc       <= 1'b0;
		end else begin
			sel_sync  <= {sel_sync[1:0], select_n_pin};
			sclk_sync <= {sclk_sync[1:0], shift_clk_pin};
			sel_lvl   <= next_sel;
			sclk_lvl  <= next_sclk;
			osc_div   <= osc_edge ? 8'h00 : osc_div + 8'h01;
			if (osc_edge) begin
				osc <= ~osc;
			end
		end
	end

	// frame sequencer
	always @(posedge clk) begin
		if (reset) begin
			state    <= `SARS_ST_IDLE;
			q_rise   <= 2'h0;
			q_fall   <= 1'b0;
			edge_cnt <= 4'h0;
			shreg    <= `SARS_ALL_ZEROS;
			last_res <= `SARS_ALL_ZEROS;
			held     <= {AW{1'b0}};
			sdo      <= 1'b0;
			sdo_oe   <= 1'b0;
		end else if (next_sel) begin
			state  <= `SARS_ST_IDLE;
			sdo_oe <= 1'b0;
		end else begin
			case (state)
			`SARS_ST_IDLE: begin
				if (sel_fall) begin
					state  <= `SARS_ST_QUAL;
					q_rise <= 2'h0;
					q_fall <= 1'b0;
				end
			end
			`SARS_ST_QUAL: begin
				if (osc_rise && q_rise != `SARS_QUAL_RISES) begin
					q_rise <= q_rise + 2'h1;
				end
				if (osc_fall) begin
					q_fall <= 1'b1;
				end
				if (qualified) begin
					// previous result, or last one again if none waits
					state    <= `SARS_ST_SHIFT;
					edge_cnt <= 4'h0;
					shreg    <= pop_valid ? pop_data : last_res;
					sdo      <= pop_valid ? pop_data[7] : last_res[7];
					sdo_oe   <= 1'b1;
					if (pop_valid) begin
						last_res <= pop_data;
					end
				end
			end
			`SARS_ST_SHIFT: begin
				if (edge_cnt >= `SARS_ACQ_FIRST_EDGE - 1 && edge_cnt < `SARS_FRAME_EDGES) begin
					held <= ain; // track, frozen from the eighth edge
				end
				if (sclk_fall && edge_cnt < `SARS_FRAME_EDGES) begin
					edge_cnt <= edge_cnt + 4'h1;
					shreg    <= {shreg[6:0], 1'b0};
					sdo      <= shreg[6];
				end
			end
			default: begin
				state <= `SARS_ST_IDLE;
			end
			endcase
		end
	end

	// conversion runs on oscillator ticks, one bit trial every four
	always @(posedge clk) begin
		if (reset) begin
			conv_busy <= 1'b0;
			tick      <= 6'h00;
			sar       <= `SARS_ALL_ZEROS;
			mask      <= `SARS_ALL_ZEROS;
			done      <= 1'b0;
			guard     <= 16'h0000;
		end else if (start) begin
			// a too-early frame abandons the running conversion
			conv_busy <= 1'b1;
			tick      <= 6'h00;
			sar       <= `SARS_ALL_ZEROS;
			mask      <= `SARS_MSB_MASK;
			done      <= 1'b0;
			guard     <= 16'h0000;
		end else if (conv_busy) begin
			if (!done) begin
				guard <= guard + 16'h0001;
			end
			if (osc_rise && !done) begin
				tick <= tick + 6'h01;
				if (tick[1:0] == `SARS_BIT_STEP - 1 && mask != `SARS_ALL_ZEROS) begin
					if ({8'h00, held} >= thr(trial, ref_lo, ref_hi)) begin
						sar <= trial;
					end
					mask <= {1'b0, mask[7:1]};
				end
			end
			if ((osc_rise && tick == `SARS_CONV_PERIODS - 1)
			    || guard == CONV_LIMIT - 1) begin
				done <= 1'b1;
				// clamp out of range inputs instead of wrapping
				if (held >= ref_hi) begin
					sar <= `SARS_ALL_ONES;
				end else if (held <= ref_lo) begin
					sar <= `SARS_ALL_ZEROS;
				end
			end
			// result waits here while the buffer is full
			if (done && push_ready) begin
				conv_busy <= 1'b0;
				done      <= 1'b0;
			end
		end
	end

	sars_fifo #(
		.W  (8),
		.D  (FIFO_DEPTH),
		.AW (FIFO_AW)
	) u_fifo (
		.clk       (clk),
		.reset     (reset),
		.in_valid  (done),
		.in_ready  (push_ready),
		.in_data   (sar),
		.out_valid (pop_valid),
		.out_ready (load),
		.out_data  (pop_data)
	);
endmodule // sars_seq

// ===== rtl/sars_map.vh
// Contract
// - eighth falling shift clock edge after select low starts a new conversion
// - conversion takes 36 internal clock periods, never beyond 17 us
// - most significant result bit is on the output before the first shift edge
// - first seven falling shift edges step output to next lower bit
// - each frame returns the result converted in the preceding frame, msb first
// - after select falls, ignore controls until two internal rises and one fall
// - inputs above upper reference give all ones, below lower give all zeros
// - analog input tracked over last four shift cycles, held at conversion start (code tracks from the third falling edge, over the last five)
// - serial output is high impedance while select is high
`ifndef SARS_MAP_VH
`define SARS_MAP_VH
`define SARS_CLK_KHZ        250000
`define SARS_OSC_KHZ        4000
`define SARS_OSC_HALF       (`SARS_CLK_KHZ / (`SARS_OSC_KHZ * 2))
`define SARS_CONV_PERIODS   36
`define SARS_CONV_MAX_NS    17000
`define SARS_CONV_MAX_CYC   ((`SARS_CONV_MAX_NS * (`SARS_CLK_KHZ / 1000)) / 1000)
`define SARS_SEL_HOLD_NS    17000
`define SARS_SEL_SETUP_NS   1400
`define SARS_FRAME_EDGES    8
`define SARS_ACQ_FIRST_EDGE 4
`define SARS_QUAL_RISES     2
`define SARS_QUAL_FALLS     1
`define SARS_BIT_STEP       4
`define SARS_MSB_MASK       8'h80
`define SARS_ALL_ONES       8'hff
`define SARS_ALL_ZEROS      8'h00
`define SARS_ST_IDLE        2'h0
`define SARS_ST_QUAL        2'h1
`define SARS_ST_SHIFT       2'h2
`endif

// ===== testbench/sars_seq_sva.sv
`timescale 1ns/1ns
module sars_seq_sva (
	input wire clk,
	input wire reset,
	input wire select_n_pin,
	input wire shift_clk_pin,
	input wire sdo,
	input wire sdo_oe,
	input wire conv_busy
);
	reg [9:0]  sel_cnt;
	reg [11:0] busy_cnt;
	reg [3:0]  fcnt;
	reg [5:0]  since_fall;
	reg        shift_q;
	wire       fall = shift_q & ~shift_clk_pin;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	always @(posedge clk) begin
		shift_q <= shift_clk_pin;
		sel_cnt <= (reset | select_n_pin) ? 10'h0 : sel_cnt + {9'h0, ~&sel_cnt};
		fcnt <= (reset | select_n_pin) ? 4'h0 : fcnt + {3'h0, fall};
		since_fall <= fall ? 6'h0 : since_fall + {5'h0, ~&since_fall};
		busy_cnt <= conv_busy ? busy_cnt + 12'h1 : 12'h0;
	end
	property p_qual; $rose(sdo_oe) |-> sel_cnt >= 10'd62; endproperty
	a_qual: assert property (p_qual) else $error("output enabled before qualification");
	property p_enable; sel_cnt == 10'd340 |-> sdo_oe; endproperty
	a_enable: assert property (p_enable) else $error("msb not driven in time");
	property p_start; fall && fcnt == 4'h7 |-> ##[1:10] $rose(conv_busy); endproperty
	a_start: assert property (p_start) else $error("eighth edge did not start");
	property p_only8; $rose(conv_busy) |-> fcnt == 4'h8; endproperty
	a_only8: assert property (p_only8) else $error("conversion began off the eighth edge");
	property p_step; $changed(sdo) && sdo_oe && $past(sdo_oe) |-> since_fall <= 6'd8; endproperty
	a_step: assert property (p_step) else $error("data moved without a falling edge");
	property p_hiz; select_n_pin [*7] |-> !sdo_oe; endproperty
	a_hiz: assert property (p_hiz) else $error("output driven while deselected");
	property p_conv_max; conv_busy |-> busy_cnt < 12'd2300; endproperty
	a_conv_max: assert property (p_conv_max) else $error("conversion too long");
	property p_conv_len; $fell(conv_busy) |-> busy_cnt >= 12'd2170; endproperty
	a_conv_len: assert property (p_conv_len) else $error("conversion too short");
endmodule // sars_seq_sva
bind sars_seq sars_seq_sva sars_seq_sva_inst (.clk(clk), .reset(reset),
	.select_n_pin(select_n_pin), .shift_clk_pin(shift_clk_pin), .sdo(sdo),
	.sdo_oe(sdo_oe), .conv_busy(conv_busy));

// ===== testbench/sars_host.sv
`timescale 1ns/1ns
module sars_host (
	input  wire       clk,
	input  wire       go,
	input  wire       sdo_line,
	output reg        select_n,
	output reg        sclk,
	output reg  [7:0] data,
	output reg        done
);
	integer i;
	initial begin
		select_n = 1'b1;
		sclk = 1'b1;
		data = 8'h00;
		done = 1'b0;
	end
	// shift clock stands high outside frames
	always @(posedge clk) begin
		if (!go) begin
			done <= 1'b0;
		end else if (!done) begin
			select_n <= 1'b0;
			repeat (400) @(posedge clk);
			for (i = 7; i >= 0; i = i - 1) begin
				data[i] <= sdo_line;
				sclk <= 1'b0;
				repeat (8) @(posedge clk);
				sclk <= 1'b1;
				repeat (8) @(posedge clk);
			end
			select_n <= 1'b1;
			repeat (4250) @(posedge clk);
			done <= 1'b1;
		end
	end
endmodule // sars_host

// ===== testbench/serial_adc_readout_sequencer_bench.sv
`timescale 1ns/1ns
module serial_adc_readout_sequencer_bench;
	reg        clk;
	reg        reset;
	reg        go;
	reg  [9:0] ain;
	wire       select_n;
	wire       sclk;
	wire       sdo;
	wire       sdo_oe;
	wire       conv_busy;
	wire       done;
	wire [7:0] data;
	wire       sdo_line = sdo_oe ? sdo : 1'bz;
	integer    mismatches;
	integer    total_checks;
	integer    cycles;
	// shorter guard keeps the run brief; still above 36 periods
	sars_seq #(.CONV_LIMIT(3000)) sars_seq_inst (.clk(clk), .reset(reset),
		.select_n_pin(select_n), .shift_clk_pin(sclk), .ain(ain), .ref_hi(10'h300),
		.ref_lo(10'h100), .sdo(sdo), .sdo_oe(sdo_oe), .conv_busy(conv_busy));
	sars_host sars_host_inst (.clk(clk), .go(go), .sdo_line(sdo_line),
		.select_n(select_n), .sclk(sclk), .data(data), .done(done));
	task finish_test;
		begin
			if (mismatches == 0 && total_checks > 0)
				$display("Run complete: PASS");
			else
				$display("Run complete: FAIL");
			$finish;
		end
	endtask
	task check(input [63:0] name, input [7:0] exp, input [7:0] got);
		begin
			total_checks = total_checks + 1;
			if (exp !== got) begin
				mismatches = mismatches + 1;
				$display("BAD %0s expected %h seen %h", name, exp, got);
			end
		end
	endtask
	task run_frame;
		integer n;
		begin
			n = 0;
			go <= 1'b1;
			while (done !== 1'b1 && n < 6000) begin
				@(posedge clk);
				n = n + 1;
			end
			// a frame that never finishes counts against the run
			if (done !== 1'b1)
				mismatches = mismatches + 1;
			go <= 1'b0;
			repeat (2) @(posedge clk);
		end
	endtask
	task t_first_frame;
		begin
			ain <= 10'h3ff;
			run_frame;
			check("first", 8'h00, data);
			check("oe", 8'h00, {7'h0, sdo_oe});
		end
	endtask
	task t_sat_high;
		begin
			ain <= 10'h000;
			run_frame;
			check("high", 8'hff, data);
			check("busy", 8'h00, {7'h0, conv_busy});
		end
	endtask
	task t_sat_low;
		begin
			// mid-scale input: ideal code (196h - 100h) * 256 / 200h = 4bh
			ain <= 10'h196;
			run_frame;
			check("low", 8'h00, data);
		end
	endtask
	task t_mid;
		begin
			// uneven bit pattern, so a reversed shift order shows
			run_frame;
			check("mid", 8'h4b, data);
		end
	endtask
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles = cycles + 1;
		if (cycles == 30000) begin
			mismatches = mismatches + 1;
			finish_test;
		end
	end
	initial begin
		reset = 1'b1;
		go = 1'b0;
		ain = 10'h000;
		mismatches = 0;
		total_checks = 0;
		cycles = 0;
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		t_first_frame;
		t_sat_high;
		t_sat_low;
		t_mid;
		finish_test;
	end
endmodule // serial_adc_readout_sequencer_bench
